/* hw/transport_channel_encoder.sv */
// Purpose: channel coding, rate matching, interleaving and frame multiplexing
// Assumes: upstream logic on sys_clk; blocks of at most 1023 bits, frames of at most 1024
// Notes: format indicator and power command bits are side outputs indexed by slot_bit_k
`timescale 1ns/1ps
`include "tce_cfg.svh"

module transport_channel_encoder
    import tce_pkg::*;
#(
    parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // channel configuration
    input chan_e chan_type,
    input coding_e coding_sel,
    input wire logic conv_half,
    input wire logic dl_mode,
    input wire logic [`CNT_W-1:0] rm_target,
    input wire logic [1:0] first_cols_log2,
    input wire logic [`LEN_W-1:0] first_rows,
    input wire logic [5:0] frame_rows,
    // transport block input
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_bit,
    input wire logic in_last,
    // multiplexed frame output
    output logic out_valid,
    input wire logic out_ready,
    output logic out_bit,
    output logic out_dtx,
    output logic out_frame_start,
    // format indicator and power command
    input wire logic [9:0] fi_index,
    input wire logic fi_split,
    input wire logic [4:0] fi_shared_index,
    input wire logic [1:0] pc_cmd,
    input wire logic [7:0] slot_bit_k,
    output logic fi_bit,
    output logic pc_bit
);
    localparam logic [4:0] COL_PERM [0:29] = `COL_PERM2;

    coder_s r;
    coder_s n;
    logic [1:0] rst_sync;
    logic rst_n;
    logic start_enc;
    logic x2;
    logic a1;
    logic a2;
    logic [8:0] win;
    logic [`ADDR_W-1:0] pnext;
    logic [`ADDR_W-1:0] out_pos;
    bit_mem_if mif ();

    bit_mem u_mem (
        .sys_clk(sys_clk),
        .port(mif)
    );

    // reset released through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    function automatic logic [2:0] bitrev(input logic [2:0] c, input logic [1:0] w);
        case (w)
            2'h0: return 3'h0;
            2'h1: return {2'h0, c[0]};
            2'h2: return {1'b0, c[0], c[1]};
            default: return {c[0], c[1], c[2]};
        endcase
    endfunction : bitrev

    function automatic logic [2:0] last_col(input logic [1:0] w);
        return 3'((4'h1 << w) - 4'h1);
    endfunction : last_col

    function automatic logic [`CNT_W-1:0] coded_len(input logic [`LEN_W-1:0] l, input coding_e s,
                                                    input logic h);
        if (s == CODE_NONE) begin
            return `CNT_W'(l);
        end else if (s == CODE_CONV && h) begin
            return `CNT_W'({l, 1'b0});
        end
        return `CNT_W'(l) * `CNT_W'(3);
    endfunction : coded_len

    // sum of basis rows: five linear, all-ones, four pair products
    function automatic logic rm32(input logic [9:0] v, input logic [4:0] k);
        logic b;
        b = v[5];
        for (int j = 0; j < 5; j++) begin
            b = b ^ (v[j] & k[j]);
        end
        b = b ^ (v[6] & k[0] & k[1]) ^ (v[7] & k[1] & k[2]) ^ (v[8] & k[2] & k[3]) ^ (v[9] & k[3] & k[4]);
        return b;
    endfunction : rm32

    function automatic logic bi16(input logic [4:0] v, input logic [3:0] k);
        logic b;
        b = v[4];
        for (int j = 0; j < 4; j++) begin
            b = b ^ (v[j] & k[j]);
        end
        return b;
    endfunction : bi16

    function automatic logic [3:0] mod15(input logic [7:0] k);
        logic [7:0] v;
        v = k;
        for (int j = 0; j < 17; j++) begin
            if (v >= `PC_SLOTS) begin
                v = v - `PC_SLOTS;
            end
        end
        return v[3:0];
    endfunction : mod15

    function automatic logic fi_code(input logic [9:0] v, input logic sp, input logic [4:0] sh,
                                     input logic [4:0] k);
        if (sp) begin
            return k[0] ? bi16(sh, k[4:1]) : bi16(v[4:0], k[4:1]);
        end
        return rm32(v, k);
    endfunction : fi_code

    assign out_pos = `ADDR_W'(r.r2) * `ADDR_W'(`COLS2) + `ADDR_W'(COL_PERM[r.c2]);
    assign x2 = mif.rdata;
    assign win = {r.x1, r.sr};
    // recursive constituents, feedback 1+D2+D3, parity 1+D+D3
    assign a1 = r.x1 ^ r.ts1[1] ^ r.ts1[2];
    assign a2 = x2 ^ r.ts2[1] ^ r.ts2[2];

    always_comb begin
        n = r;
        mif.we = 1'b0;
        mif.waddr = `IN_BASE;
        mif.wdata = 1'b0;
        mif.raddr = `IN_BASE;
        in_ready = 1'b0;
        start_enc = 1'b0;
        pnext = `ADDR_W'(r.pidx) + `ADDR_W'(`TURBO_STEP);
        n.fi_bit = fi_code(fi_index, fi_split, fi_shared_index, slot_bit_k[4:0]);
        n.pc_bit = pc_cmd[1'(mod15(slot_bit_k))];
        if (r.tick_cnt == 18'(FRAME_CYCLES - 1)) begin
            n.tick_cnt = 18'h0;
            n.tick_pend = 1'b1;
        end else begin
            n.tick_cnt = r.tick_cnt + 18'h1;
        end
        case (r.state)
            ST_IDLE: begin
                // no take while held in reset: r would not record it
                in_ready = rst_n && !r.tick_pend;
                if (r.tick_pend) begin
                    n.tick_pend = (r.tick_cnt == 18'(FRAME_CYCLES - 1));
                    n.r2 = 6'h0;
                    n.c2 = 5'h0;
                    n.rows2 = frame_rows;
                    n.ofirst = 1'b1;
                    n.state = ST_OUT_RD;
                end else if (in_valid) begin
                    mif.we = 1'b1;
                    mif.wdata = in_bit;
                    n.len = `LEN_W'(1);
                    // scheme from configuration, forced for BCH, PCH and RACH
                    if (chan_type == CH_BCH || chan_type == CH_PCH || chan_type == CH_RACH) begin
                        n.scheme = CODE_CONV;
                        n.half = 1'b1;
                    end else begin
                        n.scheme = coding_sel;
                        n.half = conv_half;
                    end
                    n.dl = dl_mode;
                    n.cols_log2 = first_cols_log2;
                    n.rows1 = first_rows;
                    n.state = ST_LOAD;
                    start_enc = in_last;
                end
            end
            ST_LOAD: begin
                in_ready = 1'b1;
                // bit taken only when valid and ready
                if (in_valid) begin
                    mif.we = 1'b1;
                    mif.waddr = `IN_BASE + `ADDR_W'(r.len);
                    mif.wdata = in_bit;
                    n.len = r.len + `LEN_W'(1);
                    start_enc = in_last || (r.len == `MAX_LEN_M1);
                end
            end
            ST_RD1: begin
                mif.raddr = `IN_BASE + `ADDR_W'(r.idx);
                n.state = ST_RD2;
            end
            ST_RD2: begin
                n.x1 = mif.rdata;
                mif.raddr = `IN_BASE + `ADDR_W'(r.pidx);
                n.state = ST_CODE;
            end
            ST_CODE: begin
                if (r.scheme == CODE_CONV && r.half) begin
                    // two taps over input plus eight stages
                    n.cb = {1'b0, ^(win & `G2_1), ^(win & `G2_0)};
                    n.ncb = 2'h2;
                    n.sr = {r.x1, r.sr[7:1]};
                end else if (r.scheme == CODE_CONV) begin
                    n.cb = {^(win & `G3_2), ^(win & `G3_1), ^(win & `G3_0)};
                    n.ncb = 2'h3;
                    n.sr = {r.x1, r.sr[7:1]};
                end else if (r.scheme == CODE_TURBO) begin
                    // systematic, parity one, parity of interleaved input
                    n.cb = {a2 ^ r.ts2[0] ^ r.ts2[2], a1 ^ r.ts1[0] ^ r.ts1[2], r.x1};
                    n.ncb = 2'h3;
                    n.ts1 = {r.ts1[1], r.ts1[0], a1};
                    n.ts2 = {r.ts2[1], r.ts2[0], a2};
                end else begin
                    n.cb = {2'h0, r.x1};
                    n.ncb = 2'h1;
                end
                n.bi = 2'h0;
                n.acc = r.acc + {1'b0, r.e_tgt};
                n.state = ST_RM;
            end
            ST_RM: begin
                // accumulator repeats or punctures toward the target
                if (r.acc >= {1'b0, r.n_tot}) begin
                    mif.we = 1'b1;
                    // row-wise write, permuted column readout order
                    mif.waddr = `ADDR_W'(`FRAME_BASE + r.base + `ADDR_W'(bitrev(r.c1, r.cols_log2))
                                * `ADDR_W'(r.rows1) + `ADDR_W'(r.r1));
                    mif.wdata = r.cb[r.bi];
                    n.acc = r.acc - {1'b0, r.n_tot};
                    n.blk_cnt = r.blk_cnt + `ADDR_W'(1);
                    if (r.c1 == last_col(r.cols_log2)) begin
                        n.c1 = 3'h0;
                        n.r1 = r.r1 + `LEN_W'(1);
                    end else begin
                        n.c1 = r.c1 + 3'h1;
                    end
                end else if (r.bi != r.ncb - 2'h1) begin
                    n.bi = r.bi + 2'h1;
                    n.acc = r.acc + {1'b0, r.e_tgt};
                end else if (r.idx == r.len - `LEN_W'(1)) begin
                    // next block appends serially to the frame
                    n.base = r.base + r.blk_cnt;
                    n.state = ST_IDLE;
                end else begin
                    n.idx = r.idx + `LEN_W'(1);
                    if (r.len <= `TURBO_STEP) begin
                        n.pidx = r.idx + `LEN_W'(1);
                    end else if (pnext >= `ADDR_W'(r.len)) begin
                        n.pidx = `LEN_W'(pnext - `ADDR_W'(r.len));
                    end else begin
                        n.pidx = `LEN_W'(pnext);
                    end
                    n.state = ST_RD1;
                end
            end
            ST_OUT_RD: begin
                // column-wise readout in fixed column order
                mif.raddr = `FRAME_BASE + out_pos;
                n.state = ST_OUT_CAP;
            end
            ST_OUT_CAP: begin
                n.ob = mif.rdata;
                // positions beyond the filled bits are gaps
                n.odtx = (out_pos >= r.base);
                n.state = ST_OUT_SEND;
            end
            ST_OUT_SEND: begin
                if (out_ready) begin
                    n.ofirst = 1'b0;
                    n.state = ST_OUT_RD;
                    if (r.r2 != r.rows2 - 6'h1) begin
                        n.r2 = r.r2 + 6'h1;
                    end else begin
                        n.r2 = 6'h0;
                        n.c2 = r.c2 + 5'h1;
                        if (r.c2 == `LAST_COL2) begin
                            n.base = `ADDR_W'(0);
                            n.state = ST_IDLE;
                        end
                    end
                end
            end
            default: n.state = ST_IDLE;
        endcase
        if (start_enc) begin
            // coder registers cleared before each block
            n.sr = 8'h0;
            n.ts1 = 3'h0;
            n.ts2 = 3'h0;
            n.idx = `LEN_W'(0);
            n.pidx = `LEN_W'(0);
            n.c1 = 3'h0;
            n.r1 = `LEN_W'(0);
            n.blk_cnt = `ADDR_W'(0);
            n.acc = '0;
            n.n_tot = coded_len(n.len, n.scheme, n.half);
            n.e_tgt = n.dl ? coded_len(n.len, n.scheme, n.half) : rm_target;
            n.state = ST_RD1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign out_valid = (r.state == ST_OUT_SEND);
    assign out_bit = r.ob;
    assign out_dtx = r.odtx;
    assign out_frame_start = r.ofirst;
    assign fi_bit = r.fi_bit;
    assign pc_bit = r.pc_bit;

    // helper: bits accepted in the current frame
    logic [`ADDR_W-1:0] sent_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sent_cnt <= '0;
        end else if (r.state == ST_IDLE) begin
            sent_cnt <= '0;
        end else if (out_valid && out_ready) begin
            sent_cnt <= sent_cnt + `ADDR_W'(1);
        end
    end

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    coder_clear_a: assert property (start_enc |=> (r.sr == 8'h0 && r.ts1 == 3'h0 && r.ts2 == 3'h0))
        else $error("coder state not cleared at block start");
    rate_match_a: assert property ((r.state == ST_RM && n.state == ST_IDLE) |-> ({1'b0, r.blk_cnt} == r.e_tgt))
        else $error("rate matched count differs from target");
    input_take_a: assert property ((r.state == ST_LOAD && in_valid && in_ready) |=> r.len == $past(r.len) + `LEN_W'(1))
        else $error("accepted input bit not counted");
    output_hold_a: assert property ((out_valid && !out_ready) |=> (out_valid && $stable(out_bit) && $stable(out_dtx)))
        else $error("output changed while stalled");
    third_rate_a: assert property ((r.state == ST_CODE && r.scheme == CODE_CONV && !r.half) |=> r.ncb == 2'h3)
        else $error("rate third did not give three bits");
    half_rate_a: assert property ((r.state == ST_CODE && r.scheme == CODE_CONV && r.half) |=> r.ncb == 2'h2)
        else $error("rate half did not give two bits");
    forced_half_a: assert property ((r.state == ST_IDLE && in_valid && in_ready
        && (chan_type == CH_BCH || chan_type == CH_PCH || chan_type == CH_RACH))
        |=> (r.scheme == CODE_CONV && r.half))
        else $error("common channel not at rate half");
    // frame is rows times thirty bits
    frame_len_a: assert property ((out_valid && out_ready && n.state == ST_IDLE)
        |-> sent_cnt + `ADDR_W'(1) == `ADDR_W'(r.rows2) * `ADDR_W'(`COLS2))
        else $error("frame length not rows times thirty");
    frame_tick_a: assert property ((r.tick_cnt == 18'(FRAME_CYCLES - 1) && r.state != ST_IDLE) |=> r.tick_pend)
        else $error("frame tick lost");
    // power command bit by slot index
    power_rep_a: assert property (1'b1 |=> pc_bit == $past(pc_cmd[1'(mod15(slot_bit_k))]))
        else $error("power command bit wrong");
    indicator_a: assert property (!fi_split |=> fi_bit == $past(rm32(fi_index, slot_bit_k[4:0])))
        else $error("indicator bit wrong");

    turbo_done_c: cover property (r.state == ST_RM && n.state == ST_IDLE && r.scheme == CODE_TURBO);
    half_done_c: cover property (r.state == ST_RM && n.state == ST_IDLE && r.half);
    repeat_c: cover property (r.state == ST_RM && r.acc >= {r.n_tot, 1'b0});
    frame_done_c: cover property (out_valid && out_ready && n.state == ST_IDLE && out_dtx);
endmodule : transport_channel_encoder

/* hw/tce_cfg.svh */
// Purpose: constants for the transport channel encoder
// Assumes: 20 MHz sys_clk, one-bit-wide buffer memory
// Notes: generators are the octal figures written in hex
`ifndef TCE_CFG_SVH
`define TCE_CFG_SVH

`define ADDR_W 11
`define LEN_W 10
`define CNT_W 12
`define MEM_DEPTH 2048
`define IN_BASE 11'h000
`define FRAME_BASE 11'h400
`define MAX_LEN_M1 10'h3FE

// second interleaver: 30 columns, fixed column order
`define COLS2 5'h1E
`define LAST_COL2 5'h1D
`define COL_PERM2 '{5'h00, 5'h14, 5'h0A, 5'h05, 5'h0F, 5'h19, 5'h03, 5'h0D, 5'h17, 5'h08, \
    5'h12, 5'h1C, 5'h01, 5'h0B, 5'h15, 5'h06, 5'h10, 5'h1A, 5'h04, 5'h0E, 5'h18, 5'h13, \
    5'h09, 5'h1D, 5'h0C, 5'h02, 5'h07, 5'h16, 5'h1B, 5'h11}

// convolutional generators, octal 557 663 711 and 561 753
`define G3_0 9'h16F
`define G3_1 9'h1B3
`define G3_2 9'h1C9
`define G2_0 9'h171
`define G2_1 9'h1EB

// turbo internal interleaver stride
`define TURBO_STEP 10'h00D

// power command codeword spans 15 slots
`define PC_SLOTS 8'h0F

// radio frame period
`define FRAME_TIME_MS 10
`define CLK_FREQ_KHZ 20000
`define FRAME_CYCLES (`FRAME_TIME_MS * `CLK_FREQ_KHZ)

`endif

/* hw/tce_pkg.sv */
// Purpose: types shared by the encoder and its testbench
// Assumes: tce_cfg.svh widths
// Notes: state struct holds every register of the encoder except rst_sync and sent_cnt
`include "tce_cfg.svh"
package tce_pkg;

    typedef enum logic [1:0] {CODE_NONE, CODE_CONV, CODE_TURBO} coding_e;

    typedef enum logic [2:0] {CH_BCH, CH_PCH, CH_RACH, CH_CPCH, CH_DCH, CH_DSCH, CH_FACH} chan_e;

    typedef enum logic [3:0] {ST_IDLE, ST_LOAD, ST_RD1, ST_RD2, ST_CODE, ST_RM,
                              ST_OUT_RD, ST_OUT_CAP, ST_OUT_SEND} coder_state_e;

    typedef struct packed {
        coder_state_e state;
        logic [`LEN_W-1:0] len;
        logic [`LEN_W-1:0] idx;
        logic [`LEN_W-1:0] pidx;
        logic x1;
        coding_e scheme;
        logic half;
        logic dl;
        logic [`CNT_W-1:0] e_tgt;
        logic [`CNT_W-1:0] n_tot;
        logic [`CNT_W:0] acc;
        logic [2:0] cb;
        logic [1:0] ncb;
        logic [1:0] bi;
        logic [7:0] sr;
        logic [2:0] ts1;
        logic [2:0] ts2;
        logic [2:0] c1;
        logic [1:0] cols_log2;
        logic [`LEN_W-1:0] r1;
        logic [`LEN_W-1:0] rows1;
        logic [`ADDR_W-1:0] blk_cnt;
        logic [`ADDR_W-1:0] base;
        logic [5:0] r2;
        logic [5:0] rows2;
        logic [4:0] c2;
        logic ob;
        logic odtx;
        logic ofirst;
        logic [17:0] tick_cnt;
        logic tick_pend;
        logic fi_bit;
        logic pc_bit;
    } coder_s;

endpackage : tce_pkg

/* hw/bit_mem_if.sv */
// Purpose: port bundle between encoder and bit buffer
// Assumes: one write and one read per cycle
// Notes: read data arrive one cycle after the address
`timescale 1ns/1ps
`include "tce_cfg.svh"
interface bit_mem_if;
    logic we;
    logic [`ADDR_W-1:0] waddr;
    logic wdata;
    logic [`ADDR_W-1:0] raddr;
    logic rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : bit_mem_if

/* hw/bit_mem.sv */
// Purpose: one-bit-wide buffer for blocks and frames
// Assumes: single clock, no reset on contents
// Notes: registered read, write and read may share a cycle
`timescale 1ns/1ps
`include "tce_cfg.svh"
module bit_mem (
    // clock
    input wire logic sys_clk,
    // access port
    bit_mem_if.mem port
);
    logic store [0:`MEM_DEPTH-1];

    always_ff @(posedge sys_clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
        port.rdata <= store[port.raddr];
    end
endmodule : bit_mem

/* tb/spread_sink.sv */
// Purpose: downstream spreader model pacing the output stream
// Assumes: sys_clk domain, bit taken on valid and ready
// Notes: slow mode accepts one cycle in three
`timescale 1ns/1ps
module spread_sink (
    // clock
    input wire logic sys_clk,
    // pacing
    input wire logic slow,
    // stream
    output logic out_ready
);
    logic [1:0] ph_reg = 2'h0;
    always_ff @(posedge sys_clk) begin
        ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
        out_ready <= !slow || (ph_reg == 2'h0);
    end
endmodule : spread_sink

/* tb/test_transport_channel_encoder.sv */
// Purpose: frame and side output checks of the encoder
// Assumes: one 30-bit frame row, one first-interleaver column
// Notes: one block per frame so buffer fill restarts each frame
`timescale 1ns/1ps
`include "tce_cfg.svh"
module test_transport_channel_encoder;
    import tce_pkg::*;
    localparam int L = 10;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    chan_e chan_type = CH_DCH;
    coding_e coding_sel = CODE_NONE;
    logic conv_half = 1'b0, dl_mode = 1'b1, slow = 1'b0;
    logic [11:0] rm_target = 12'h001;
    logic [9:0] first_rows = 10'h001, fi_index = 10'h000;
    logic in_valid = 1'b0, in_bit = 1'b0, in_last = 1'b0, fi_split = 1'b0;
    logic [4:0] fi_shared_index = 5'h00;
    logic [1:0] pc_cmd = 2'h0;
    logic [7:0] slot_bit_k = 8'h00;
    logic in_ready, out_valid, out_ready, out_bit, out_dtx, out_frame_start, fi_bit, pc_bit;
    logic [4:0] perm [30] = `COL_PERM2;
    int miscompares = 0, n_checks = 0;
    chan_e tch [6] = '{CH_DCH, CH_DCH, CH_BCH, CH_DCH, CH_FACH, CH_DSCH};
    coding_e tcs [6] = '{CODE_CONV, CODE_CONV, CODE_CONV, CODE_NONE, CODE_CONV, CODE_TURBO};
    logic thf [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    int tee [6] = '{0, 0, 0, 15, 13, 24};
    transport_channel_encoder #(.FRAME_CYCLES(2000)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .chan_type(chan_type), .coding_sel(coding_sel), .conv_half(conv_half), .dl_mode(dl_mode),
        .rm_target(rm_target), .first_cols_log2(2'h0), .first_rows(first_rows), .frame_rows(6'h01),
        .in_valid(in_valid), .in_ready(in_ready), .in_bit(in_bit), .in_last(in_last),
        .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit), .out_dtx(out_dtx),
        .out_frame_start(out_frame_start), .fi_index(fi_index), .fi_split(fi_split),
        .fi_shared_index(fi_shared_index), .pc_cmd(pc_cmd), .slot_bit_k(slot_bit_k),
        .fi_bit(fi_bit), .pc_bit(pc_bit));
    spread_sink sink (.sys_clk(sys_clk), .slow(slow), .out_ready(out_ready));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [29:0] got, input logic [29:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // coded, then rate-matched bits of one block
    function automatic int model(input logic [9:0] pat, input logic hf, input coding_e cs, input int ee,
                                 output logic [89:0] q);
        logic [89:0] c;
        logic [7:0] h;
        logic [8:0] w;
        logic [2:0] s;
        logic a;
        int nc, n, acc;
        nc = 0;
        h = 8'h00;
        s = 3'h0;
        for (int i = 0; i < L; i++) begin
            w = {pat[i], h};
            if (cs == CODE_NONE) begin
                c[nc++] = pat[i];
            end else if (cs == CODE_TURBO) begin
                // blocks of 13 bits or fewer: both constituents see the same input
                a = pat[i] ^ s[1] ^ s[2];
                c[nc++] = pat[i];
                c[nc++] = a ^ s[0] ^ s[2];
                c[nc++] = a ^ s[0] ^ s[2];
                s = {s[1:0], a};
            end else if (hf) begin
                c[nc++] = ^(w & `G2_0);
                c[nc++] = ^(w & `G2_1);
            end else begin
                c[nc++] = ^(w & `G3_0);
                c[nc++] = ^(w & `G3_1);
                c[nc++] = ^(w & `G3_2);
            end
            h = {pat[i], h[7:1]};
        end
        if (ee == 0) ee = nc;
        n = 0;
        acc = 0;
        for (int j = 0; j < nc; j++) begin
            acc += ee;
            while (acc >= nc) begin
                q[n++] = c[j];
                acc -= nc;
            end
        end
        return n;
    endfunction : model
    function automatic logic fi_exp(input logic [9:0] v, input logic sp, input logic [4:0] sh,
                                    input logic [4:0] k);
        logic [4:0] u;
        u = k[0] ? sh : v[4:0];
        if (sp) return u[4] ^ ^(u[3:0] & k[4:1]);
        return v[5] ^ ^(v[4:0] & k) ^ (v[6] & k[0] & k[1]) ^ (v[7] & k[1] & k[2]) ^ (v[8] & k[2] & k[3])
            ^ (v[9] & k[3] & k[4]);
    endfunction : fi_exp
    task automatic send(input logic [9:0] pat);
        logic ok;
        for (int i = 0; i < L; i++) begin
            in_valid <= 1'b1;
            in_bit <= pat[i];
            in_last <= (i == L - 1);
            do begin
                @(negedge sys_clk);
                ok = in_ready;
                @(posedge sys_clk);
            end while (!ok);
        end
        in_valid <= 1'b0;
    endtask : send
    task automatic frame(output logic [29:0] fb, output logic [29:0] fd);
        logic ok;
        for (int p = 0; p < 30; p++) begin
            do begin
                @(negedge sys_clk);
                ok = out_valid && out_ready && (p > 0 || out_frame_start);
                fb[p] = out_bit;
                fd[p] = out_dtx;
                @(posedge sys_clk);
            end while (!ok);
        end
    endtask : frame
    initial begin
        logic [29:0] fb, fd, eb, ed;
        logic [89:0] q;
        int n;
        repeat (20) @(posedge sys_clk);
        chk({28'h0, in_ready, out_valid}, 30'h0);
        reset_n <= 1'b1;
        for (int t = 0; t < 6; t++) begin
            frame(fb, fd);
            slow <= t[0];
            chan_type <= tch[t];
            coding_sel <= tcs[t];
            conv_half <= thf[t];
            dl_mode <= (tee[t] == 0);
            n = model(10'h2D3 ^ 10'(t * 77), thf[t] || tch[t] == CH_BCH, tcs[t], tee[t], q);
            rm_target <= 12'(n);
            first_rows <= 10'(n);
            send(10'h2D3 ^ 10'(t * 77));
            frame(fb, fd);
            for (int p = 0; p < 30; p++) begin
                ed[p] = (perm[p] >= n);
                eb[p] = ed[p] ? 1'b0 : q[perm[p]];
            end
            chk(fd, ed);
            chk(fb & ~fd, eb);
            $display("frame test %0d done", t);
        end
        for (int v = 0; v < 3; v++) begin
            for (int k = 0; k < 70; k++) begin
                @(posedge sys_clk);
                fi_index <= 10'h2B5 ^ {10{v[0]}};
                fi_split <= (v == 2);
                fi_shared_index <= 5'h0E;
                pc_cmd <= 2'(v + 1);
                slot_bit_k <= 8'(k);
                @(posedge sys_clk);
                @(negedge sys_clk);
                chk({29'h0, fi_bit}, {29'h0, fi_exp(fi_index, fi_split, 5'h0E, slot_bit_k[4:0])});
                chk({29'h0, pc_bit}, {29'h0, pc_cmd[(k % 15) % 2]});
            end
            $display("side test %0d done", v);
        end
        final_report();
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        final_report();
    end
endmodule : test_transport_channel_encoder
